// ---- adc_result_postproc.sv ----
// converter result holding, calibration coefficients, result counter and comparator
`timescale 1ns/1ps
`default_nettype none
module adc_result_postproc (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic PRI_VALID_I,
  input wire logic [23:0] PRI_DATA_I,
  input wire logic AUX_VALID_I,
  input wire logic [23:0] AUX_DATA_I,
  input wire logic CAL_VALID_I,
  input wire logic CAL_AUX_I,
  input wire logic CAL_GAIN_I,
  input wire logic [15:0] CAL_DATA_I,
  output logic [2:0] MODE_O,
  output logic PRI_EN_O,
  output logic AUX_EN_O,
  output logic [15:0] PRI_OFFSET_O,
  output logic [15:0] AUX_OFFSET_O,
  output logic [15:0] PRI_GAIN_O,
  output logic [15:0] AUX_GAIN_O,
  output logic IRQ_O
);
  import adc_postproc_pkg::*;

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] off);
    addr_is = (a == off);
  endfunction

  // bus state
  logic dp_write_reg;
  logic rd_pend_reg;
  logic [31:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  // software registers
  logic [5:0] mode_reg;
  logic [5:0] mode_next;
  logic [4:0] config_reg;
  logic [1:0] pchcfg_reg;
  logic [3:0] irq_en_reg;
  logic [3:0] status_reg;
  logic [3:0] status_next;
  logic irq_reg;
  logic [23:0] pri_result_reg;
  logic [23:0] aux_result_reg;
  logic [15:0] pri_off_reg;
  logic [15:0] aux_off_reg;
  logic [15:0] pri_gain_reg;
  logic [15:0] aux_gain_reg;
  logic [15:0] rc_limit_reg;
  logic [15:0] rc_value_reg;
  logic [15:0] rc_value_next;
  logic [15:0] thresh_reg;
  logic [7:0] th_limit_reg;
  logic [7:0] th_value_reg;
  logic [7:0] th_value_next;
  logic [10:0] idle_cnt_reg;

  // address phase and data phase strobes
  wire addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I & (HSIZE_I == 3'h2);
  wire wr_fire = dp_write_reg;
  wire rd_fire = rd_pend_reg;
  wire sel_mode = addr_is(dp_addr_reg, MODE_ADDR);
  wire sel_cfg = addr_is(dp_addr_reg, CONFIG_ADDR);
  wire sel_pch = addr_is(dp_addr_reg, PCHCFG_ADDR);
  wire sel_ien = addr_is(dp_addr_reg, IRQ_EN_ADDR);
  wire sel_iclr = addr_is(dp_addr_reg, IRQ_CLR_ADDR);
  wire sel_pres = addr_is(dp_addr_reg, PRI_RESULT_ADDR);
  wire sel_ares = addr_is(dp_addr_reg, AUX_RESULT_ADDR);
  wire sel_poff = addr_is(dp_addr_reg, PRI_OFFSET_ADDR);
  wire sel_aoff = addr_is(dp_addr_reg, AUX_OFFSET_ADDR);
  wire sel_pgain = addr_is(dp_addr_reg, PRI_GAIN_ADDR);
  wire sel_again = addr_is(dp_addr_reg, AUX_GAIN_ADDR);
  wire sel_rclim = addr_is(dp_addr_reg, RC_LIMIT_ADDR);
  wire sel_th = addr_is(dp_addr_reg, THRESH_ADDR);
  wire sel_thlim = addr_is(dp_addr_reg, TH_LIMIT_ADDR);

  // read mux; unmapped addresses read zero
  wire [31:0] rdata =
    ({32{addr_is(dp_addr_reg, STATUS_ADDR)}} & {28'h000_0000, status_reg}) |
    ({32{sel_mode}} & {26'h000_0000, mode_reg}) |
    ({32{sel_cfg}} & {27'h000_0000, config_reg}) |
    ({32{sel_pch}} & {30'h0000_0000, pchcfg_reg}) |
    ({32{sel_ien}} & {28'h000_0000, irq_en_reg}) |
    ({32{sel_pres}} & {8'h00, pri_result_reg}) |
    ({32{sel_ares}} & {8'h00, aux_result_reg}) |
    ({32{sel_poff}} & {16'h0000, pri_off_reg}) |
    ({32{sel_aoff}} & {16'h0000, aux_off_reg}) |
    ({32{sel_pgain}} & {16'h0000, pri_gain_reg}) |
    ({32{sel_again}} & {16'h0000, aux_gain_reg}) |
    ({32{sel_rclim}} & {16'h0000, rc_limit_reg}) |
    ({32{addr_is(dp_addr_reg, RC_VALUE_ADDR)}} & {16'h0000, rc_value_reg}) |
    ({32{sel_th}} & {16'h0000, thresh_reg}) |
    ({32{sel_thlim}} & {24'h00_0000, th_limit_reg}) |
    ({32{addr_is(dp_addr_reg, TH_VALUE_ADDR)}} & {24'h00_0000, th_value_reg});

  // coefficient write window: enabled, idle, and idle long enough to settle
  wire idle_now = (mode_reg[2:0] == MODE_IDLE);
  wire idle_long = idle_now & (idle_cnt_reg == IDLE_MIN_COUNT);
  wire pri_coef_ok = idle_long & mode_reg[MODE_PRI_EN_BIT];
  wire aux_coef_ok = idle_long & mode_reg[MODE_AUX_EN_BIT];

  // calibration completion, accepted only in the matching user cal mode
  wire cal_take = CAL_VALID_I & ((mode_reg[2:0] == MODE_OFFSET_CAL & !CAL_GAIN_I) |
                                 (mode_reg[2:0] == MODE_GAIN_CAL & CAL_GAIN_I));
  wire cal_pri_off = cal_take & !CAL_AUX_I & !CAL_GAIN_I;
  wire cal_aux_off = cal_take & CAL_AUX_I & !CAL_GAIN_I;
  wire cal_pri_gain = cal_take & !CAL_AUX_I & CAL_GAIN_I;
  wire cal_aux_gain = cal_take & CAL_AUX_I & CAL_GAIN_I;

  // result counter
  wire rc_en = config_reg[CFG_RC_EN_BIT];
  wire rc_adv = PRI_VALID_I & rc_en;
  wire [15:0] rc_inc = rc_value_reg + 16'h0001;
  wire rc_hit = rc_adv & (rc_inc == rc_limit_reg);
  wire rc_clr = wr_fire & (sel_mode | sel_pch);
  assign rc_value_next = rc_clr ? 16'h0000 :
                         rc_hit ? 16'h0000 :
                         rc_adv ? rc_inc : rc_value_reg;
  wire pri_irq_evt = PRI_VALID_I & (!rc_en | rc_hit);

  // comparator: magnitude against threshold
  wire twos = pchcfg_reg[PCH_TWOS_BIT];
  wire [1:0] cmp_mode = config_reg[CFG_CMP_LSB +: 2];
  wire [23:0] neg_data = 24'(~PRI_DATA_I + 24'h00_0001);
  wire [23:0] mag = (twos & PRI_DATA_I[23]) ? neg_data : PRI_DATA_I;
  // full-scale negative has bit 23 set and always reaches the threshold
  wire mag_ge = twos ? (mag[23] | (mag[22:8] >= thresh_reg[14:0])) :
                       (PRI_DATA_I[23:8] >= thresh_reg);
  wire [7:0] th_inc = (th_value_reg == 8'hFF) ? th_value_reg :
                      8'(th_value_reg + 8'h01);
  wire [7:0] th_dec = (th_value_reg == 8'h00) ? th_value_reg :
                      8'(th_value_reg - 8'h01);
  wire [7:0] th_cand = mag_ge ? th_inc :
                       (cmp_mode == CMP_COUNT_DEC) ? th_dec : 8'h00;
  assign th_value_next = (PRI_VALID_I & cmp_mode[1]) ? th_cand : th_value_reg;
  wire cmp_evt = PRI_VALID_I & (((cmp_mode == CMP_EACH) & mag_ge) |
                 (cmp_mode[1] & (th_cand == th_limit_reg)));

  // sticky status; set wins over every clear
  wire [3:0] set_vec = {cal_take, cmp_evt, AUX_VALID_I, pri_irq_evt};
  wire [3:0] clr_sw = (wr_fire & sel_iclr) ? HWDATA_I[3:0] : 4'h0;
  wire [3:0] clr_pri = (rd_fire & sel_pres) ? 4'h7 : 4'h0;
  wire [3:0] clr_aux = (rd_fire & sel_ares) ? 4'h6 : 4'h0;
  assign status_next = (status_reg & ~(clr_sw | clr_pri | clr_aux)) | set_vec;

  wire pri_store = PRI_VALID_I & !status_reg[ST_PRI_READY];
  wire aux_store = AUX_VALID_I & !status_reg[ST_AUX_READY];
  wire [23:0] pri_fmt = pchcfg_reg[PCH_16BIT_BIT] ? {8'h00, PRI_DATA_I[23:8]} :
                        PRI_DATA_I;

  // software write wins over a finishing calibration, which returns to idle
  assign mode_next = (wr_fire & sel_mode) ? HWDATA_I[5:0] :
                     cal_take ? {mode_reg[5:3], MODE_IDLE} : mode_reg;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dp_write_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      dp_addr_reg <= 32'h0000_0000;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      // reads take one wait state so the data leaves a flop
      dp_write_reg <= addr_ok & HWRITE_I;
      rd_pend_reg <= addr_ok & !HWRITE_I;
      hreadyout_reg <= !(addr_ok & !HWRITE_I);
      hresp_reg <= 1'b0;
      if (addr_ok) begin
        dp_addr_reg <= HADDR_I;
      end
      if (rd_pend_reg) begin
        hrdata_reg <= rdata;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mode_reg <= 6'h00;
      config_reg <= 5'h00;
      pchcfg_reg <= 2'h0;
      irq_en_reg <= 4'h0;
      status_reg <= 4'h0;
      irq_reg <= 1'b0;
      idle_cnt_reg <= 11'h000;
    end else begin
      mode_reg <= mode_next;
      status_reg <= status_next;
      irq_reg <= |(status_next & irq_en_reg);
      idle_cnt_reg <= !idle_now ? 11'h000 :
                      idle_long ? idle_cnt_reg : 11'(idle_cnt_reg + 11'h001);
      if (wr_fire & sel_cfg) begin
        config_reg <= HWDATA_I[4:0];
      end
      if (wr_fire & sel_pch) begin
        pchcfg_reg <= HWDATA_I[1:0];
      end
      if (wr_fire & sel_ien) begin
        irq_en_reg <= HWDATA_I[3:0];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pri_result_reg <= 24'h00_0000;
      aux_result_reg <= 24'h00_0000;
    end else begin
      if (pri_store) begin
        pri_result_reg <= pri_fmt;
      end
      if (aux_store) begin
        aux_result_reg <= AUX_DATA_I;
      end
    end
  end

  // calibration results take precedence over a software write in the same cycle
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pri_off_reg <= FACTORY_PRI_OFFSET;
      aux_off_reg <= FACTORY_AUX_OFFSET;
      pri_gain_reg <= FACTORY_PRI_GAIN;
      aux_gain_reg <= FACTORY_AUX_GAIN;
    end else begin
      if (cal_pri_off) begin
        pri_off_reg <= CAL_DATA_I;
      end else if (wr_fire & sel_poff & pri_coef_ok) begin
        pri_off_reg <= HWDATA_I[15:0];
      end
      if (cal_aux_off) begin
        aux_off_reg <= CAL_DATA_I;
      end else if (wr_fire & sel_aoff & aux_coef_ok) begin
        aux_off_reg <= HWDATA_I[15:0];
      end
      if (cal_pri_gain) begin
        pri_gain_reg <= CAL_DATA_I;
      end else if (wr_fire & sel_pgain & pri_coef_ok) begin
        pri_gain_reg <= HWDATA_I[15:0];
      end
      if (cal_aux_gain) begin
        aux_gain_reg <= CAL_DATA_I;
      end else if (wr_fire & sel_again & aux_coef_ok) begin
        aux_gain_reg <= HWDATA_I[15:0];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rc_limit_reg <= RC_LIMIT_RST;
      rc_value_reg <= 16'h0000;
      thresh_reg <= 16'h0000;
      th_limit_reg <= TH_LIMIT_RST;
      th_value_reg <= 8'h00;
    end else begin
      rc_value_reg <= rc_value_next;
      th_value_reg <= th_value_next;
      if (wr_fire & sel_rclim) begin
        rc_limit_reg <= HWDATA_I[15:0];
      end
      if (wr_fire & sel_th) begin
        thresh_reg <= HWDATA_I[15:0];
      end
      if (wr_fire & sel_thlim) begin
        th_limit_reg <= HWDATA_I[7:0];
      end
    end
  end

  assign HRDATA_O = hrdata_reg;
  assign HREADYOUT_O = hreadyout_reg;
  assign HRESP_O = hresp_reg;
  assign MODE_O = mode_reg[2:0];
  assign PRI_EN_O = mode_reg[MODE_PRI_EN_BIT];
  assign AUX_EN_O = mode_reg[MODE_AUX_EN_BIT];
  assign PRI_OFFSET_O = pri_off_reg;
  assign AUX_OFFSET_O = aux_off_reg;
  assign PRI_GAIN_O = pri_gain_reg;
  assign AUX_GAIN_O = aux_gain_reg;
  assign IRQ_O = irq_reg;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  property p_pri_hold;
    status_reg[ST_PRI_READY] |=> $stable(pri_result_reg);
  endproperty
  a_pri_hold: assert property (p_pri_hold) else $error("primary result overwritten");
  property p_pri_read_clear;
    (rd_fire && sel_pres && set_vec[2:0] == 3'h0) |=> (status_reg[2:0] == 3'h0);
  endproperty
  a_pri_read_clear: assert property (p_pri_read_clear)
    else $error("primary read left a flag");
  property p_aux_hold;
    status_reg[ST_AUX_READY] |=> $stable(aux_result_reg);
  endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("aux result overwritten");
  property p_aux_read_clear;
    (rd_fire && sel_ares && set_vec[2:1] == 2'h0) |=>
      (status_reg[2:1] == 2'h0) && (status_reg[0] == $past(status_reg[0]) || $past(set_vec[0]));
  endproperty
  a_aux_read_clear: assert property (p_aux_read_clear)
    else $error("aux read cleared wrong flags");
  // a software mode write in the same cycle keeps its own mode
  sequence s_offset_cal_pri;
    CAL_VALID_I && !CAL_AUX_I && !CAL_GAIN_I && mode_reg[2:0] == MODE_OFFSET_CAL &&
      !(wr_fire && sel_mode);
  endsequence
  property p_offset_cal;
    s_offset_cal_pri |=> (pri_off_reg == $past(CAL_DATA_I)) && (mode_reg[2:0] == MODE_IDLE);
  endproperty
  a_offset_cal: assert property (p_offset_cal) else $error("offset cal not loaded");
  property p_gain_cal;
    (CAL_VALID_I && CAL_AUX_I && CAL_GAIN_I && mode_reg[2:0] == MODE_GAIN_CAL) |=>
      (aux_gain_reg == $past(CAL_DATA_I));
  endproperty
  a_gain_cal: assert property (p_gain_cal) else $error("gain cal not loaded");
  property p_coef_guard;
    (wr_fire && sel_poff && !pri_coef_ok && !cal_pri_off) |=> $stable(pri_off_reg);
  endproperty
  a_coef_guard: assert property (p_coef_guard) else $error("coefficient written when busy");
  property p_irq_rate;
    (PRI_VALID_I && rc_en && rc_inc != rc_limit_reg && !status_reg[ST_PRI_READY]) |=>
      !status_reg[ST_PRI_READY];
  endproperty
  a_irq_rate: assert property (p_irq_rate) else $error("interrupt before limit");
  property p_rc_wrap;
    (rc_adv && rc_inc == rc_limit_reg) |=> (rc_value_reg == 16'h0000);
  endproperty
  a_rc_wrap: assert property (p_rc_wrap) else $error("result count did not wrap");
  property p_rc_clear;
    (wr_fire && (sel_mode || sel_pch)) |=> (rc_value_reg == 16'h0000);
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("result count not cleared");
  // irq is judged in the same cycle as the flag; a later read may clear both
  property p_unipolar_cmp;
    (PRI_VALID_I && !twos && cmp_mode == CMP_EACH && PRI_DATA_I[23:8] >= thresh_reg) |=>
      status_reg[ST_CMP_HIT] && (IRQ_O || !$past(irq_en_reg[ST_CMP_HIT]));
  endproperty
  a_unipolar_cmp: assert property (p_unipolar_cmp) else $error("comparator missed");
  property p_cmp_limit;
    (PRI_VALID_I && cmp_mode[1] && th_cand == th_limit_reg) |=> status_reg[ST_CMP_HIT];
  endproperty
  a_cmp_limit: assert property (p_cmp_limit) else $error("count limit flag missing");
  property p_th_count_up;
    (PRI_VALID_I && cmp_mode == CMP_COUNT_CLR && mag_ge && th_value_reg != 8'hFF) |=>
      (th_value_reg == $past(th_value_reg) + 8'h01);
  endproperty
  a_th_count_up: assert property (p_th_count_up) else $error("threshold count not raised");
  property p_cmp_off;
    (cmp_mode == CMP_OFF) |=> $stable(th_value_reg);
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("count moved while off");
  property p_no_limit_irq;
    (PRI_VALID_I && !rc_en) |=> status_reg[ST_PRI_READY];
  endproperty
  a_no_limit_irq: assert property (p_no_limit_irq) else $error("ready missing");
  property p_th_floor;
    (PRI_VALID_I && cmp_mode == CMP_COUNT_DEC && !mag_ge && th_value_reg == 8'h00) |=>
      (th_value_reg == 8'h00);
  endproperty
  a_th_floor: assert property (p_th_floor) else $error("threshold count underflow");
endmodule
`default_nettype wire

// ---- adc_postproc_pkg.sv ----
// constants for the converter result post-processing block
package adc_postproc_pkg;
  // register byte addresses
  localparam logic [31:0] STATUS_ADDR = 32'hFFFF_0500;
  localparam logic [31:0] MODE_ADDR = 32'hFFFF_0504;
  localparam logic [31:0] CONFIG_ADDR = 32'hFFFF_0508;
  localparam logic [31:0] PCHCFG_ADDR = 32'hFFFF_050C;
  localparam logic [31:0] IRQ_EN_ADDR = 32'hFFFF_0510;
  localparam logic [31:0] IRQ_CLR_ADDR = 32'hFFFF_0514;
  localparam logic [31:0] PRI_RESULT_ADDR = 32'hFFFF_051C;
  localparam logic [31:0] AUX_RESULT_ADDR = 32'hFFFF_0520;
  localparam logic [31:0] PRI_OFFSET_ADDR = 32'hFFFF_0524;
  localparam logic [31:0] AUX_OFFSET_ADDR = 32'hFFFF_0528;
  localparam logic [31:0] PRI_GAIN_ADDR = 32'hFFFF_052C;
  localparam logic [31:0] AUX_GAIN_ADDR = 32'hFFFF_0530;
  localparam logic [31:0] RC_LIMIT_ADDR = 32'hFFFF_0534;
  localparam logic [31:0] RC_VALUE_ADDR = 32'hFFFF_0538;
  localparam logic [31:0] THRESH_ADDR = 32'hFFFF_053C;
  localparam logic [31:0] TH_LIMIT_ADDR = 32'hFFFF_0540;
  localparam logic [31:0] TH_VALUE_ADDR = 32'hFFFF_0544;
  // status / interrupt bit positions
  localparam int ST_PRI_READY = 0;
  localparam int ST_AUX_READY = 1;
  localparam int ST_CMP_HIT = 2;
  localparam int ST_CAL_DONE = 3;
  // field positions
  localparam int CFG_RC_EN_BIT = 0;
  localparam int CFG_CMP_LSB = 3;
  localparam int PCH_TWOS_BIT = 0;
  localparam int PCH_16BIT_BIT = 1;
  localparam int MODE_PRI_EN_BIT = 4;
  localparam int MODE_AUX_EN_BIT = 5;
  // converter modes (mode register bits 2:0)
  localparam logic [2:0] MODE_POWERDOWN = 3'h0;
  localparam logic [2:0] MODE_CONT = 3'h1;
  localparam logic [2:0] MODE_SINGLE = 3'h2;
  localparam logic [2:0] MODE_IDLE = 3'h3;
  localparam logic [2:0] MODE_OFFSET_CAL = 3'h4;
  localparam logic [2:0] MODE_GAIN_CAL = 3'h5;
  // comparator modes
  localparam logic [1:0] CMP_OFF = 2'h0;
  localparam logic [1:0] CMP_EACH = 2'h1;
  localparam logic [1:0] CMP_COUNT_CLR = 2'h2;
  localparam logic [1:0] CMP_COUNT_DEC = 2'h3;
  // reset values
  localparam logic [15:0] RC_LIMIT_RST = 16'h0001;
  localparam logic [7:0] TH_LIMIT_RST = 8'h01;
  localparam logic [15:0] FACTORY_PRI_OFFSET = 16'h8000;
  localparam logic [15:0] FACTORY_AUX_OFFSET = 16'h8000;
  localparam logic [15:0] FACTORY_PRI_GAIN = 16'h5555;
  localparam logic [15:0] FACTORY_AUX_GAIN = 16'h5555;
  // least idle time before a coefficient write
  localparam int IDLE_MIN_NS = 23000;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [10:0] IDLE_MIN_COUNT =
    11'((IDLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ---- conv_pipe_model.sv ----
// converter pipeline stand-in: result and calibration pulses
`timescale 1ns/1ps
`default_nettype none
module conv_pipe_model (
  input wire logic clk_i,
  output logic pv_o,
  output logic [23:0] pd_o,
  output logic av_o,
  output logic [23:0] ad_o,
  output logic cv_o,
  output logic ca_o,
  output logic cg_o,
  output logic [15:0] cd_o
);
  initial {pv_o, pd_o, av_o, ad_o, cv_o, ca_o, cg_o, cd_o} = '0;
  // data flips after the pulse so a stale word never looks current
  task automatic send_pri(input logic [23:0] d);
    pv_o <= 1'h1;
    pd_o <= d;
    @(posedge clk_i);
    pv_o <= 1'h0;
    pd_o <= ~d;
    @(posedge clk_i) #1;
  endtask
  task automatic send_aux(input logic [23:0] d);
    av_o <= 1'h1;
    ad_o <= d;
    @(posedge clk_i);
    av_o <= 1'h0;
    ad_o <= ~d;
    @(posedge clk_i) #1;
  endtask
  task automatic send_cal(input logic a, input logic g, input logic [15:0] d);
    cv_o <= 1'h1;
    ca_o <= a;
    cg_o <= g;
    cd_o <= d;
    @(posedge clk_i);
    cv_o <= 1'h0;
    cd_o <= ~d;
    @(posedge clk_i) #1;
  endtask
endmodule
`default_nettype wire

// ---- adc_result_postproc_test.sv ----
// self-checking bench for the converter result post-processing block
`timescale 1ns/1ps
`default_nettype none
module adc_result_postproc_test;
  import adc_postproc_pkg::*;
  logic clk, rst_b, hsel, hwrite, hrdy, hresp, irq, pv, av, cv, ca, cg, pen, aen, hit;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [23:0] pd, ad, d;
  logic [15:0] cd, po, ao, pg, ag;
  logic [2:0] mode, hsize;
  logic [7:0] cnt;
  int errors, check_count, seed;
  adc_result_postproc DUT (.CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .PRI_VALID_I(pv), .PRI_DATA_I(pd), .AUX_VALID_I(av), .AUX_DATA_I(ad), .CAL_VALID_I(cv),
    .CAL_AUX_I(ca), .CAL_GAIN_I(cg), .CAL_DATA_I(cd), .MODE_O(mode), .PRI_EN_O(pen),
    .AUX_EN_O(aen), .PRI_OFFSET_O(po), .AUX_OFFSET_O(ao), .PRI_GAIN_O(pg),
    .AUX_GAIN_O(ag), .IRQ_O(irq));
  conv_pipe_model pipe (.clk_i(clk), .pv_o(pv), .pd_o(pd), .av_o(av), .ad_o(ad),
    .cv_o(cv), .ca_o(ca), .cg_o(cg), .cd_o(cd));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // magnitude test: two's complement drops threshold bit 15
  function automatic logic hitf(logic [23:0] x, logic tw, logic [15:0] th);
    logic [23:0] a;
    a = (tw && x[23]) ? -x : x;
    return tw ? (a[23] || a[22:8] >= th[14:0]) : (x[23:8] >= th);
  endfunction
  // threshold count: saturates at both ends
  function automatic logic [7:0] thn(logic [7:0] c, logic [1:0] m, logic h);
    if (m < 2) return c;
    if (h) return (c == 8'hFF) ? c : c + 8'h1;
    if (m == 2) return 8'h0;
    return (c == 8'h0) ? c : c - 8'h1;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'h1);
    r = hrdata;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    bus(1'h1, a, wd, q);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    // a few thousand cycles expected; allow ample margin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    stop_test;
  end
  initial begin
    seed = 32'h73d9;
    {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk) #1;
    chk(po, FACTORY_PRI_OFFSET);
    chk(ag, FACTORY_AUX_GAIN);
    chk(hresp, 1'h0);
    rc(RC_LIMIT_ADDR, 32'h1);
    rc(TH_LIMIT_ADDR, 32'h1);
    rc(TH_VALUE_ADDR, 32'h0);
    rc(RC_VALUE_ADDR, 32'h0);
    $display("reset test done");
    pipe.send_pri(24'h12_3456);
    pipe.send_pri(24'h65_4321);
    pipe.send_aux(24'hA5_5A5A);
    pipe.send_aux(24'h00_0001);
    rc(AUX_RESULT_ADDR, 32'hA5_5A5A);
    rc(STATUS_ADDR, 32'h1);
    rc(PRI_RESULT_ADDR, 32'h12_3456);
    rc(STATUS_ADDR, 32'h0);
    wr(IRQ_EN_ADDR, 32'h2);
    pipe.send_aux(24'h33);
    chk(irq, 1'h1);
    pipe.send_pri(24'h44);
    wr(IRQ_CLR_ADDR, 32'h2);
    @(posedge clk) #1;
    chk(irq, 1'h0);
    rc(PRI_RESULT_ADDR, 32'h44);
    $display("result test done");
    wr(PRI_OFFSET_ADDR, 32'h1234);
    chk(po, FACTORY_PRI_OFFSET);
    wr(MODE_ADDR, 32'h13);
    chk({aen, pen, 1'b0, mode}, 32'h13);
    wr(PRI_OFFSET_ADDR, 32'h1234);
    chk(po, FACTORY_PRI_OFFSET);
    repeat (IDLE_MIN_COUNT) @(posedge clk);
    wr(PRI_OFFSET_ADDR, 32'h1234);
    wr(AUX_OFFSET_ADDR, 32'h4321);
    chk(po, 32'h1234);
    chk(ao, FACTORY_AUX_OFFSET);
    wr(MODE_ADDR, 32'h34);
    chk({aen, pen, 1'b0, mode}, 32'h34);
    pipe.send_cal(1'h0, 1'h1, 16'hBEEF);
    chk(pg, FACTORY_PRI_GAIN);
    pipe.send_cal(1'h0, 1'h0, 16'h0F0F);
    chk(po, 32'h0F0F);
    chk(mode, MODE_IDLE);
    wr(MODE_ADDR, 32'h35);
    pipe.send_cal(1'h1, 1'h1, 16'h7777);
    chk(ag, 32'h7777);
    $display("coefficient test done");
    wr(IRQ_EN_ADDR, 32'h1);
    wr(CONFIG_ADDR, 32'h1);
    wr(RC_LIMIT_ADDR, 32'h3);
    wr(PCHCFG_ADDR, 32'h0);
    repeat (2) pipe.send_pri(24'($random(seed)));
    chk(irq, 1'h0);
    rc(RC_VALUE_ADDR, 32'h2);
    pipe.send_pri(24'($random(seed)));
    chk(irq, 1'h1);
    rc(RC_VALUE_ADDR, 32'h0);
    pipe.send_pri(24'($random(seed)));
    wr(MODE_ADDR, 32'h13);
    rc(RC_VALUE_ADDR, 32'h0);
    rc(RC_LIMIT_ADDR, 32'h3);
    // halfword transfers are ignored by the slave
    hsize <= 3'h1;
    wr(RC_LIMIT_ADDR, 32'h9);
    hsize <= 3'h2;
    rc(RC_LIMIT_ADDR, 32'h3);
    bus(1'h0, PRI_RESULT_ADDR, 32'h0, q);
    $display("counter test done");
    wr(IRQ_EN_ADDR, 32'h4);
    wr(THRESH_ADDR, 32'hC000);
    wr(TH_LIMIT_ADDR, 32'h2);
    cnt = 8'h0;
    for (int m = 0; m < 4; m++) begin
      wr(CONFIG_ADDR, 32'(m) << CFG_CMP_LSB);
      wr(PCHCFG_ADDR, 32'(m == 3));
      for (int i = 0; i < 24; i++) begin
        d = (i == 0) ? 24'h80_0000 : 24'($random(seed)) | ((i % 3) ? 24'hC0_0000 : 24'h0);
        hit = hitf(d, m == 3, 16'hC000);
        cnt = thn(cnt, 2'(m), hit);
        pipe.send_pri(d);
        rc(TH_VALUE_ADDR, cnt);
        hit = (m == 1) ? hit : (m > 1 && cnt == 8'h2);
        bus(1'h0, STATUS_ADDR, 32'h0, q);
        chk(q[ST_CMP_HIT], hit);
        chk(irq, hit);
        bus(1'h0, PRI_RESULT_ADDR, 32'h0, q);
      end
    end
    $display("comparator test done");
    stop_test;
  end
endmodule
`default_nettype wire
